//--- mad_decode.sv
// Memory address decoder: steers core accesses to data RAM, SFR space,
// external-space RAM and program flash. Core drives req on the mclk domain.
`timescale 1ns/1ps
// Overview of operation
// - 256-byte data RAM, upper half dual-mapped
// - Upper half: indirect to RAM, direct SFR
// - Lower half always reaches RAM cells
// - First 32 bytes are four register banks
// - Next 16 bytes byte and bit addressable
// - 1024-byte RAM across whole 64k space
// - Flash reprogrammable in 512-byte sectors
// - 0x3E00 to 0x3FFF reserved for factory
// - Extra 128-byte flash block at 0x8000
module mad_decode (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire mad_pkg::mad_req_t req,
   output mad_pkg::mad_rsp_t      rsp
);
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   wire logic is_idata = req.valid && (req.space == mad_pkg::MAD_SP_IDATA);
   wire logic is_xdata = req.valid && (req.space == mad_pkg::MAD_SP_XDATA);
   wire logic is_code  = req.valid && (req.space == mad_pkg::MAD_SP_CODE);
   wire logic [7:0] ia = req.addr[7:0];
   wire logic upper    = ia >= mad_pkg::IDATA_UPPER_BASE;
   wire logic sfr_sel  = is_idata && upper && !req.indirect;
   wire logic iram_sel = is_idata && (!upper || req.indirect);
   wire logic xram_sel = is_xdata;
   wire logic [9:0] xidx = req.addr[mad_pkg::XRAM_AW-1:0];
   wire logic rsv      = is_code && in_range(req.addr, mad_pkg::CODE_RSV_BASE,
                                             mad_pkg::CODE_RSV_END);
   wire logic main_hit = is_code && (req.addr <= mad_pkg::CODE_MAIN_END) && !rsv;
   wire logic xtra_hit = is_code && in_range(req.addr, mad_pkg::CODE_EXTRA_BASE,
                                             mad_pkg::CODE_EXTRA_END);
   // Extra block lands just past the main array in the flash index space
   wire logic [14:0] fidx = xtra_hit ? {1'b1, 7'h00, req.addr[6:0]} : {1'b0, req.addr[13:0]};
   // Each erase sector spans 512 bytes of the flash index space
   wire logic [6:0] sect = {1'b0, fidx[14:9]};
   wire logic bank_area = iram_sel && (ia <= mad_pkg::IDATA_BANK_END);
   wire logic bit_area  = iram_sel && (ia >= mad_pkg::IDATA_BIT_BASE)
                          && (ia <= mad_pkg::IDATA_BIT_END);
   wire logic unmapped = req.valid && !(iram_sel || sfr_sel || xram_sel || main_hit
                         || xtra_hit || rsv);
   // Writes to flash go through the sector erase/program path, not here
   wire logic iram_we = iram_sel && req.write;
   wire logic xram_we = xram_sel && req.write;

   logic [7:0] iram_rd;
   logic [7:0] xram_rd;
   mad_pkg::mad_rsp_t dec_d;
   mad_pkg::mad_rsp_t dec_q;
   mad_pkg::mad_rsp_t rsp_d;
   mad_pkg::mad_rsp_t rsp_q;

   mad_ram #(.DEPTH(mad_pkg::IDATA_SIZE), .AW(8)) u_iram (
      .mclk  (mclk),
      .we    (iram_we),
      .addr  (ia),
      .wdata (req.wdata),
      .rdata (iram_rd)
   );

   mad_ram #(.DEPTH(mad_pkg::XRAM_SIZE), .AW(mad_pkg::XRAM_AW)) u_xram (
      .mclk  (mclk),
      .we    (xram_we),
      .addr  (xidx),
      .wdata (req.wdata),
      .rdata (xram_rd)
   );

   // RAM read data stand one cycle after the taking edge, so the decode
   // result is held for that cycle and the answer is built behind it.
   // Latency is therefore one edge from the taking edge to rsp.valid.
   wire logic        hit_flash = main_hit || xtra_hit;
   wire logic [7:0]  ram_idx   = is_idata ? ia : 8'h00;
   wire logic [9:0]  xram_idx  = xram_sel ? xidx : 10'h000;
   wire logic [14:0] flash_idx = hit_flash ? fidx : 15'h0000;
   wire logic [1:0]  bank_no   = bank_area ? ia[4:3] : 2'h0;
   wire logic [6:0]  sect_no   = is_code ? sect : 7'h00;

   always_comb begin
      dec_d             = '0;
      dec_d.valid       = req.valid;
      dec_d.hit_iram    = iram_sel;
      dec_d.hit_sfr     = sfr_sel;
      dec_d.hit_xram    = xram_sel;
      dec_d.hit_flash   = hit_flash;
      dec_d.reserved    = rsv;
      dec_d.unmapped    = unmapped;
      dec_d.ram_index   = ram_idx;
      dec_d.xram_index  = xram_idx;
      dec_d.flash_index = flash_idx;
      dec_d.sector      = sect_no;
      dec_d.bank        = bank_no;
      dec_d.bit_area    = bit_area;
      dec_d.rdata       = 8'h00;
   end

   // SFR registers live outside this block, so a direct upper read returns zero
   wire logic [7:0] rd_sel = dec_q.hit_xram ? xram_rd : (dec_q.hit_iram ? iram_rd : 8'h00);

   always_comb begin
      rsp_d       = dec_q;
      rsp_d.rdata = rd_sel;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         dec_q <= '0;
         rsp_q <= '0;
      end else begin
         dec_q <= dec_d;
         rsp_q <= rsp_d;
      end
   end

   assign rsp = rsp_q;
endmodule

//--- mad_pkg.sv
// Package for the memory address decoder: address map constants and carrier types.
// Assumes a single system clock domain; used by mad_decode, mad_decode_sva, mad_core and the testbench.
package mad_pkg;
   localparam int IDATA_SIZE      = 256;
   localparam logic [7:0] IDATA_UPPER_BASE = 8'h80;
   localparam logic [7:0] IDATA_BANK_END   = 8'h1F;
   localparam logic [7:0] IDATA_BIT_BASE   = 8'h20;
   localparam logic [7:0] IDATA_BIT_END    = 8'h2F;
   localparam int XRAM_SIZE       = 1024;
   localparam int XRAM_AW         = 10;
   localparam logic [15:0] CODE_MAIN_END   = 16'h3FFF;
   localparam logic [15:0] CODE_RSV_BASE   = 16'h3E00;
   localparam logic [15:0] CODE_RSV_END    = 16'h3FFF;
   localparam logic [15:0] CODE_EXTRA_BASE = 16'h8000;
   localparam logic [15:0] CODE_EXTRA_END  = 16'h807F;
   localparam int SECTOR_BITS     = 9;
   localparam int SECTOR_AW       = 7;

   typedef enum logic [1:0] {
      MAD_SP_IDATA = 2'h0,
      MAD_SP_XDATA = 2'h1,
      MAD_SP_CODE  = 2'h2
   } mad_space_t;

   typedef struct packed {
      logic        valid;
      mad_space_t  space;
      logic        indirect;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mad_req_t;

   typedef struct packed {
      logic        valid;
      logic        hit_iram;
      logic        hit_sfr;
      logic        hit_xram;
      logic        hit_flash;
      logic        reserved;
      logic        unmapped;
      logic [7:0]  ram_index;
      logic [9:0]  xram_index;
      logic [14:0] flash_index;
      logic [6:0]  sector;
      logic [1:0]  bank;
      logic        bit_area;
      logic [7:0]  rdata;
   } mad_rsp_t;
endpackage

//--- mad_ram.sv
// Small synchronous RAM with registered read data.
// Assumes one clock; write and read in the same cycle return the old word.
`timescale 1ns/1ps
module mad_ram #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic          mclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic [7:0]         rdata
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge mclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

//--- mad_decode_sva.sv
// Checker for the address decoder: map properties on each answer.
// Assumes one request is outstanding until rsp.valid answers it.
`timescale 1ns/1ps
module mad_decode_sva (
   input wire logic              mclk,
   input wire logic              nrst,
   input wire mad_pkg::mad_req_t req,
   input wire mad_pkg::mad_rsp_t rsp
);
   mad_pkg::mad_req_t r_q;
   wire logic [15:0] a = r_q.addr;
   wire logic id = rsp.valid && r_q.space == mad_pkg::MAD_SP_IDATA;
   wire logic xd = rsp.valid && r_q.space == mad_pkg::MAD_SP_XDATA;
   wire logic cd = rsp.valid && r_q.space == mad_pkg::MAD_SP_CODE;
   always_ff @(posedge mclk) if (req.valid) r_q <= req;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_low_ram: assert property (id && !a[7] |-> rsp.hit_iram && rsp.ram_index == a[7:0])
      else $error("low ram");
   a_up_ind: assert property (id && a[7] && r_q.indirect |-> rsp.hit_iram && !rsp.hit_sfr)
      else $error("upper indirect");
   a_up_dir: assert property (id && a[7] && !r_q.indirect |-> rsp.hit_sfr && !rsp.hit_iram)
      else $error("upper direct");
   a_bank_sel: assert property (id && a[7:5] == 3'h0 |-> rsp.bank == a[4:3])
      else $error("bank");
   a_bit_area: assert property (id |-> rsp.bit_area == (a[7:4] == 4'h2))
      else $error("bit area");
   a_xram_idx: assert property (xd |-> rsp.hit_xram && rsp.xram_index == a[9:0])
      else $error("xram index");
   a_code_rsv: assert property (cd |-> rsp.reserved == (a >= 16'h3E00 && a <= 16'h3FFF))
      else $error("reserved");
   a_code_extra: assert property (cd && a >= 16'h8000 && a <= 16'h807F |-> rsp.hit_flash)
      else $error("extra flash");
   a_sector_no: assert property (cd && a < 16'h3E00 |-> rsp.hit_flash && rsp.sector == a[15:9])
      else $error("sector");
endmodule
bind mad_decode mad_decode_sva mad_decode_sva_inst (.mclk(mclk), .nrst(nrst), .req(req), .rsp(rsp));

//--- mad_core.sv
// Core model: issues one read or write request, valid for a single cycle.
// Assumes the decoder takes req at the rising edge.
`timescale 1ns/1ps
module mad_core (
   input  wire logic        mclk,
   output mad_pkg::mad_req_t req
);
   initial req = '0;
   task automatic issue(input mad_pkg::mad_space_t sp, input logic ind, input logic [15:0] ad);
      @(negedge mclk);
      req <= '{1'b1, sp, ind, 1'b0, ad, 8'h00};
      @(negedge mclk);
      req.valid <= 1'b0;
   endtask
   task automatic issue_wr(input mad_pkg::mad_space_t sp, input logic ind, input logic [15:0] ad,
                           input logic [7:0] wd);
      @(negedge mclk);
      req <= '{1'b1, sp, ind, 1'b1, ad, wd};
      @(negedge mclk);
      req.valid <= 1'b0;
   endtask
endmodule

//--- testbench.sv
// Testbench for the address decoder; core model drives requests.
// Assumes one answer per request within eight cycles.
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   int   failures = 0;
   int   tests_run = 0;
   int   cycles = 0;
   mad_pkg::mad_req_t req;
   mad_pkg::mad_rsp_t rsp;
   always #2 mclk = ~mclk;
   mad_core mad_core_inst (.mclk(mclk), .req(req));
   mad_decode mad_decode_inst (.mclk(mclk), .nrst(nrst), .req(req), .rsp(rsp));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic await_rsp();
      int n;
      n = 0;
      while (rsp.valid !== 1'b1 && n < 8) begin
         @(negedge mclk);
         n++;
      end
      chk(16'(rsp.valid), 16'h0001);
   endtask
   task automatic acc(input mad_pkg::mad_space_t sp, input logic ind, input logic [15:0] ad);
      mad_core_inst.issue(sp, ind, ad);
      await_rsp();
   endtask
   task automatic test_ram();
      mad_core_inst.issue_wr(mad_pkg::MAD_SP_IDATA, 1'b1, 16'h00C3, 8'h5A);
      await_rsp();
      acc(mad_pkg::MAD_SP_IDATA, 1'b1, 16'h00C3);
      chk(16'(rsp.rdata), 16'h005A);
      mad_core_inst.issue_wr(mad_pkg::MAD_SP_XDATA, 1'b0, 16'h0123, 8'hA5);
      await_rsp();
      acc(mad_pkg::MAD_SP_XDATA, 1'b0, 16'hFD23);
      chk(16'(rsp.rdata), 16'h00A5);
      acc(mad_pkg::MAD_SP_CODE, 1'b0, 16'h5000);
      chk({rsp.hit_flash, rsp.unmapped}, 16'h0001);
      $display("ram test done");
   endtask
   task automatic test_idata();
      acc(mad_pkg::MAD_SP_IDATA, 1'b0, 16'h0005);
      chk({rsp.hit_iram, rsp.ram_index}, 16'h0105);
      acc(mad_pkg::MAD_SP_IDATA, 1'b1, 16'h00A0);
      chk({rsp.hit_iram, rsp.hit_sfr}, 16'h0002);
      acc(mad_pkg::MAD_SP_IDATA, 1'b0, 16'h00A0);
      chk({rsp.hit_iram, rsp.hit_sfr}, 16'h0001);
      acc(mad_pkg::MAD_SP_IDATA, 1'b0, 16'h001F);
      chk({rsp.bank, rsp.bit_area}, 16'h0006);
      acc(mad_pkg::MAD_SP_IDATA, 1'b1, 16'h002F);
      chk(16'(rsp.bit_area), 16'h0001);
      $display("idata test done");
   endtask
   task automatic test_xram_code();
      acc(mad_pkg::MAD_SP_XDATA, 1'b0, 16'hFFFF);
      chk({rsp.hit_xram, rsp.xram_index}, 16'h07FF);
      acc(mad_pkg::MAD_SP_CODE, 1'b0, 16'h3DFF);
      chk({rsp.reserved, rsp.sector}, 16'h001E);
      acc(mad_pkg::MAD_SP_CODE, 1'b0, 16'h3E00);
      chk(16'(rsp.reserved), 16'h0001);
      acc(mad_pkg::MAD_SP_CODE, 1'b0, 16'h807F);
      chk(16'(rsp.hit_flash), 16'h0001);
      $display("xram and code test done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Ceiling well above the few dozen cycles the tests need
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         stop_test();
      end
   end
   initial begin
      repeat (12) @(negedge mclk);
      nrst = 1'b1;
      test_idata();
      test_xram_code();
      test_ram();
      stop_test();
   end
endmodule
